// ===== hw/axis_counter.sv
`timescale 1ns/1ps
// One scan axis: walks window plus border and blanking, mirrored if asked
module axis_counter
	import readout_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Control
	input wire logic step,
	input wire logic restart,
	input wire logic [11:0] start,
	input wire logic [11:0] size,
	input wire logic [11:0] blank,
	input wire logic [1:0] factor,
	input wire logic skip,
	input wire logic mirror,
	input wire logic border,
	input wire logic show,
	// Status
	output logic active,
	output logic edge_pix,
	output logic wrap,
	output logic [11:0] addr
);
	logic [11:0] pos;
	wire [11:0] pad = border ? BORDER_EXTRA : 12'h000;
	wire [11:0] lo_pad = border ? BORDER_PIX : 12'h000;
	wire [4:0] stride = skip ? 5'(5'h02 << factor) : 5'h01;
	wire [11:0] span = size + pad;
	// Hidden border is spent as extra blanking
	wire [11:0] total = span + blank;
	wire [11:0] win = pos - lo_pad;
	wire [11:0] step_off = 12'(win * 12'(stride));
	assign wrap = step && (pos == total - 12'h001);
	assign edge_pix = border && (pos < lo_pad || pos >= lo_pad + size);
	assign active = (pos < span) && (show || !edge_pix);
	assign addr = mirror ? start + size - step_off
		: start + step_off;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			pos <= 12'h000;
		else if (restart || wrap)
			pos <= 12'h000;
		else if (step)
			pos <= pos + 12'h001;
	end

	// Border on must stretch the scan by exactly the pad, shown or not
	a_axis_wrap: assert property (@(posedge mclk)
		disable iff (!rst_b)
		wrap |-> pos == size + blank - 12'h001
		+ (border ? BORDER_EXTRA : 12'h000))
		else $error("axis length wrong");
endmodule : axis_counter

// ===== hw/pixel_readout_mode.sv
`timescale 1ns/1ps
module pixel_readout_mode
	import readout_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Context
	input wire logic context_select_bit,
	// Pixel port
	output logic frame_valid,
	output logic line_valid,
	output logic border_pixel,
	output logic [11:0] col_addr,
	output logic [11:0] row_addr,
	output logic adc_single,
	output logic binning
);
	logic [15:0] read_mode_ctx_a;
	logic [15:0] read_mode_ctx_b;
	logic [11:0] col_size;
	logic [11:0] row_size;
	mode_t cur;
	logic slow;
	logic frame_start_seen;

	wire wr_a = reg_wr && reg_addr == REG_READ_MODE_A;
	wire wr_b = reg_wr && reg_addr == REG_READ_MODE_B;
	wire wr_g = reg_wr && reg_addr == REG_GEOMETRY;
	wire [15:0] sel = context_select_bit ? read_mode_ctx_b
		: read_mode_ctx_a;
	wire show = sel[BIT_SHOW_BORDER];
	mode_t next_mode;
	assign next_mode.bin = sel[BIT_BIN];
	assign next_mode.one_adc = sel[BIT_ONE_ADC];
	assign next_mode.border = sel[BIT_BORDER];
	assign next_mode.col_skip = sel[BIT_COL_SKIP];
	assign next_mode.col_factor = sel[6:5];
	assign next_mode.row_skip = sel[BIT_ROW_SKIP];
	assign next_mode.row_factor = sel[3:2];
	assign next_mode.mirror_col = sel[BIT_MIRROR_COL];
	assign next_mode.mirror_row = sel[BIT_MIRROR_ROW];

	// Half rate in single-converter mode: step every other clock
	wire step = !cur.one_adc || slow;
	wire col_wrap;
	wire row_wrap;
	wire col_act;
	wire row_act;
	wire col_edge;
	wire row_edge;
	wire [11:0] c_addr;
	wire [11:0] r_addr;
	wire frame_end = row_wrap;
	pixel_t next_pix;
	assign next_pix.frame_valid = row_act;
	assign next_pix.line_valid = row_act && col_act;
	assign next_pix.border_pix = row_act && col_act && (row_edge || col_edge);
	assign next_pix.col = c_addr;
	assign next_pix.row = r_addr;

	axis_counter u_col (
		.mclk(mclk), .rst_b(rst_b), .step(step), .restart(1'b0),
		.start(COL_START), .size(col_size), .blank(H_BLANK),
		.factor(cur.col_factor), .skip(cur.col_skip),
		.mirror(cur.mirror_col), .border(cur.border), .show(show),
		.active(col_act), .edge_pix(col_edge), .wrap(col_wrap),
		.addr(c_addr)
	);
	axis_counter u_row (
		.mclk(mclk), .rst_b(rst_b), .step(col_wrap), .restart(1'b0),
		.start(ROW_START), .size(row_size), .blank(V_BLANK),
		.factor(cur.row_factor), .skip(cur.row_skip),
		.mirror(cur.mirror_row), .border(cur.border), .show(show),
		.active(row_act), .edge_pix(row_edge), .wrap(row_wrap),
		.addr(r_addr)
	);

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			read_mode_ctx_a <= RESET_MODE_A;
			read_mode_ctx_b <= RESET_MODE_B;
			col_size <= RESET_COL_SIZE;
			row_size <= RESET_ROW_SIZE;
		end
		else
		begin
			if (wr_a)
				read_mode_ctx_a <= reg_wdata;
			if (wr_b)
				read_mode_ctx_b <= reg_wdata;
			if (wr_g)
			begin
				col_size <= {4'h0, reg_wdata[7:0]};
				row_size <= {4'h0, reg_wdata[15:8]};
			end
		end
	end

	// Mode fields only move between frames; show is not latched and follows the selected context at once
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cur <= mode_t'(11'h000);
			slow <= 1'b0;
			frame_start_seen <= 1'b0;
		end
		else
		begin
			slow <= cur.one_adc ? !slow : 1'b0;
			if (frame_end || !frame_start_seen)
			begin
				cur <= next_mode;
				frame_start_seen <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			frame_valid <= 1'b0;
			line_valid <= 1'b0;
			border_pixel <= 1'b0;
			col_addr <= 12'h000;
			row_addr <= 12'h000;
			adc_single <= 1'b0;
			binning <= 1'b0;
			reg_rdata <= 16'h0000;
		end
		else
		begin
			frame_valid <= next_pix.frame_valid;
			line_valid <= next_pix.line_valid;
			border_pixel <= next_pix.border_pix;
			col_addr <= next_pix.col;
			row_addr <= next_pix.row;
			adc_single <= cur.one_adc;
			binning <= cur.bin;
			if (reg_rd)
			begin
				case (reg_addr)
					REG_READ_MODE_A: reg_rdata <= read_mode_ctx_a;
					REG_READ_MODE_B: reg_rdata <= read_mode_ctx_b;
					REG_GEOMETRY: reg_rdata <= {row_size[7:0], col_size[7:0]};
					REG_STATUS: reg_rdata <= {5'h00, cur};
					default: reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	a_ctx_select: assert property (@(posedge mclk)
		disable iff (!rst_b)
		(frame_end && context_select_bit) |=>
		cur.bin == $past(read_mode_ctx_b[BIT_BIN]))
		else $error("context B not used");
	a_line_in_frame: assert property (@(posedge mclk)
		disable iff (!rst_b)
		line_valid |-> frame_valid)
		else $error("line outside frame");
	// A border pixel may only leave if show was set when it was formed
	a_hidden_border: assert property (@(posedge mclk)
		disable iff (!rst_b)
		border_pixel |-> $past(show))
		else $error("hidden border shown");
	a_half_rate: assert property (@(posedge mclk)
		disable iff (!rst_b)
		(cur.one_adc && step) |=> !step || !cur.one_adc)
		else $error("single converter too fast");
	// Two converters: a plain line must advance one column every clock
	a_full_rate: assert property (@(posedge mclk)
		disable iff (!rst_b)
		(!cur.one_adc && !cur.mirror_col && !cur.col_skip
		&& line_valid && next_pix.line_valid)
		|=> col_addr == $past(col_addr) + 12'h001)
		else $error("dual converter stalled");
	a_reset_bin: assert property (@(posedge mclk)
		disable iff (!rst_b)
		$rose(rst_b) |-> read_mode_ctx_a[BIT_BIN])
		else $error("binning reset");
	a_frame_sync: assert property (@(posedge mclk)
		disable iff (!rst_b)
		(!frame_end && frame_start_seen) |=> $stable(cur))
		else $error("mode moved mid frame");
	a_mirror_col: assert property (@(posedge mclk)
		disable iff (!rst_b)
		(cur.mirror_col && !cur.col_skip && !cur.border && col_act)
		|-> c_addr > COL_START)
		else $error("mirror start");
endmodule : pixel_readout_mode

// ===== hw/readout_pkg.sv
// Contract
// - Border pad set adds four-pixel border, eight extra rows and columns.
// - Pad on, display off: border hidden, blanking grows eight rows and pixels.
// - Pad on, display on: frame and line strobes run eight longer.
// - Context select one uses context B fields, zero uses context A.
// - Bit 7 of active context enables column skipping.
// - Column mirror reads from start plus size down to start plus one.
// - No column mirror reads from start up to start plus size minus one.
// - Row mirror reads from start plus size down to start plus one.
// - No row mirror reads from start up to start plus size minus one.
// - Context A bit 15 enables binning and resets to one.
// - Single converter bit halves readout rate to half master clock.
// - Single converter clear uses both converters at full speed.
package readout_pkg;
	localparam logic [7:0] REG_READ_MODE_B = 8'h20;
	localparam logic [7:0] REG_READ_MODE_A = 8'h21;
	localparam logic [7:0] REG_GEOMETRY = 8'h30;
	localparam logic [7:0] REG_STATUS = 8'h31;
	localparam logic [15:0] RESET_MODE_A = 16'h8490;
	localparam logic [15:0] RESET_MODE_B = 16'h0000;
	localparam int BIT_BIN = 15;
	localparam int BIT_ONE_ADC = 10;
	localparam int BIT_SHOW_BORDER = 9;
	localparam int BIT_BORDER = 8;
	localparam int BIT_COL_SKIP = 7;
	localparam int BIT_ROW_SKIP = 4;
	localparam int BIT_MIRROR_COL = 1;
	localparam int BIT_MIRROR_ROW = 0;
	localparam logic [11:0] BORDER_PIX = 12'h004;
	localparam logic [11:0] BORDER_EXTRA = 12'h008;
	localparam logic [11:0] COL_START = 12'h000;
	localparam logic [11:0] ROW_START = 12'h000;
	localparam logic [11:0] RESET_COL_SIZE = 12'h010;
	localparam logic [11:0] RESET_ROW_SIZE = 12'h008;
	localparam logic [11:0] H_BLANK = 12'h004;
	localparam logic [11:0] V_BLANK = 12'h002;

	typedef struct packed {
		logic bin;
		logic one_adc;
		logic border;
		logic col_skip;
		logic [1:0] col_factor;
		logic row_skip;
		logic [1:0] row_factor;
		logic mirror_col;
		logic mirror_row;
	} mode_t;

	typedef struct packed {
		logic frame_valid;
		logic line_valid;
		logic border_pix;
		logic [11:0] col;
		logic [11:0] row;
	} pixel_t;
endpackage : readout_pkg

// ===== tb/pixel_host.sv
`timescale 1ns/1ps
// Host capture side: measures the shape of each frame it is handed
module pixel_host
	import readout_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Pixel port
	input wire logic frame_valid,
	input wire logic line_valid,
	input wire logic [11:0] col_addr,
	input wire logic [11:0] row_addr,
	// Captured frame shape
	output logic [11:0] line_len,
	output logic [11:0] n_lines,
	output logic [11:0] first_col,
	output logic [11:0] second_col,
	output logic [11:0] first_row,
	output logic [7:0] frames
);
	logic [11:0] pos, lines, c0, c1;
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{line_len, n_lines, first_col, second_col, first_row} <= '0;
			{pos, lines, c0, c1, frames} <= '0;
		end
		else
		begin
			if (line_valid)
				pos <= pos + 12'h001;
			if (line_valid && pos == 12'h000)
				lines <= lines + 12'h001;
			if (line_valid && pos == 12'h000)
				c0 <= col_addr;
			if (line_valid && pos == 12'h001)
				c1 <= col_addr;
			if (line_valid && pos == 12'h000 && lines == 12'h000)
				first_row <= row_addr;
			if (!line_valid && pos != 12'h000)
			begin
				line_len <= pos;
				first_col <= c0;
				second_col <= c1;
				pos <= 12'h000;
			end
			// Lines are counted at their start, so a shared falling edge is safe
			if (!frame_valid && !line_valid && lines != 12'h000)
			begin
				n_lines <= lines;
				lines <= 12'h000;
				frames <= frames + 8'h01;
			end
		end
	end
endmodule : pixel_host

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench
	import readout_pkg::*;
;
	logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, ctx = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
	logic frame_valid, line_valid, border_pixel, adc_single, binning;
	logic [11:0] col_addr, row_addr, ll, nl, fc, sc, fr;
	logic [7:0] frames;
	int fails = 0, n_compared = 0;
	logic [15:0] n_border = 16'h0000, nb;
	// Read before the design's own update on the same edge
	always @(posedge mclk)
	begin
		if (border_pixel)
			n_border <= n_border + 16'h0001;
	end
	pixel_readout_mode i_pixel_readout_mode(.mclk(mclk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .context_select_bit(ctx),
		.frame_valid(frame_valid), .line_valid(line_valid),
		.border_pixel(border_pixel), .col_addr(col_addr),
		.row_addr(row_addr), .adc_single(adc_single), .binning(binning));
	pixel_host i_pixel_host(.mclk(mclk), .rst_b(rst_b),
		.frame_valid(frame_valid), .line_valid(line_valid),
		.col_addr(col_addr), .row_addr(row_addr), .line_len(ll),
		.n_lines(nl), .first_col(fc), .second_col(sc), .first_row(fr),
		.frames(frames));
	initial
	begin
		forever #2.5 mclk = ~mclk;
	end
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge mclk);
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(negedge mclk);
		reg_wr = 0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(negedge mclk);
		{reg_addr, reg_rd} = {a, 1'b1};
		@(negedge mclk);
		reg_rd = 0;
		rv = reg_rdata;
	endtask : rd
	// Two frame ends: the first latches the new mode, the second is measured
	task frames2;
		logic [7:0] f;
		repeat (2)
		begin
			f = frames;
			for (int i = 0; i < 3000 && frames == f; i++)
				@(negedge mclk);
			if (frames == f)
				chk(16'h0001, 16'h0000);
		end
	endtask : frames2
	initial
	begin
		#200000;
		fails++;
		complete_run();
	end
	initial
	begin
		repeat (2) @(negedge mclk);
		rst_b = 1'b1;
		rd(REG_READ_MODE_A);
		chk(rv, 16'h8490);
		rd(REG_READ_MODE_B);
		chk(rv, 16'h0000);
		wr(8'h7F, 16'hFFFF);
		rd(8'h7F);
		chk(rv, 16'h0000);
		// Status packs bin, one_adc, border above the low byte of the mode
		rd(REG_STATUS);
		chk(rv, 16'h0690);
		chk({14'h0, binning, adc_single}, 16'h0003);
		$display("test reset done");
		wr(REG_READ_MODE_A, 16'h0003);
		rd(REG_STATUS);
		chk(rv, 16'h0690);
		frames2();
		chk({fc, fr[3:0]}, 16'h0108);
		chk(sc, 16'h000F);
		wr(REG_READ_MODE_A, 16'h0000);
		frames2();
		chk({fc, fr[3:0]}, 16'h0000);
		chk({sc, ll[3:0]}, 16'h0010);
		chk(ll, 16'h0010);
		chk({nl, 3'h0, adc_single}, 16'h0080);
		$display("test mirror done");
		wr(REG_READ_MODE_A, 16'h0300);
		frames2();
		chk({ll, 4'h0}, 16'h0180);
		chk(nl, 16'h0010);
		// Two whole shown frames: 24x16 minus the 16x8 inner window each
		nb = n_border;
		frames2();
		chk(n_border - nb, 16'h0200);
		wr(REG_READ_MODE_A, 16'h0100);
		frames2();
		chk({ll, 4'h0}, 16'h0100);
		chk(nl, 16'h0008);
		nb = n_border;
		frames2();
		chk(n_border - nb, 16'h0000);
		$display("test border done");
		ctx = 1'b1;
		for (int f = 0; f < 4; f++)
		begin
			wr(REG_READ_MODE_B, 16'(16'h0090 | (f << 5) | (f << 2)));
			frames2();
			chk(sc - fc, 16'h0002 << f);
			rd(REG_STATUS);
			chk(rv, 16'(16'h0090 | (f << 5) | (f << 2)));
		end
		wr(REG_READ_MODE_A, 16'h8000);
		ctx = 1'b0;
		frames2();
		chk({15'h0, binning}, 16'h0001);
		$display("test context done");
		complete_run();
	end
endmodule : testbench
